// File: rtl/emm_pkg.sv
// Package for the emulator memory mapper: register map, field layouts, types.
// Assumes a 32-bit APB register bus and a 24-bit processor address.
package emm_pkg;
    localparam int EMM_ENTRIES = 8;
    localparam int EMM_ADDR_W = 24;
    localparam int EMM_PAGE_LSB = 8;
    localparam int EMM_BLOCK_LSB = 16;
    localparam int EMM_NUM_BLOCKS = 8;
    localparam int EMM_BLK_W = 3;
    localparam int EMM_PAGE_W = EMM_ADDR_W - EMM_PAGE_LSB;
    localparam int EMM_BLKWORDS = 1 << (EMM_BLOCK_LSB - EMM_PAGE_LSB);

    // Register byte addresses
    localparam logic [11:0] EMM_CTRL_OFS = 12'h000;
    localparam logic [11:0] EMM_STAT_OFS = 12'h004;
    localparam logic [11:0] EMM_MASK_OFS = 12'h008;
    localparam logic [11:0] EMM_BRKA_OFS = 12'h00C;
    localparam logic [11:0] EMM_ENT_BASE_OFS = 12'h100;
    localparam logic [11:0] EMM_ENT_STRIDE = 12'h010;

    // Control fields
    localparam int EMM_CTRL_ROMBRK = 0;
    localparam int EMM_CTRL_RT = 1;
    localparam int EMM_CTRL_ENA = 2;
    localparam int EMM_DEF_TYPE_LSB = 4;
    localparam logic [31:0] EMM_CTRL_RST = 32'h0000_0000;

    // Status / mask bits
    localparam int EMM_ST_GUARD = 0;
    localparam int EMM_ST_ROMWR = 1;
    localparam int EMM_ST_DMAREJ = 2;
    localparam int EMM_ST_HOSTREF = 3;
    localparam int EMM_ST_W = 4;

    // Entry word offsets (within stride): 0 start page, 4 end page, 8 attributes
    localparam logic [3:0] EMM_EW_START = 4'h0;
    localparam logic [3:0] EMM_EW_END = 4'h4;
    localparam logic [3:0] EMM_EW_ATTR = 4'h8;
    localparam int EMM_AT_TYPE_LSB = 0;
    localparam int EMM_AT_FCEN = 3;
    localparam int EMM_AT_FC_LSB = 4;
    localparam int EMM_AT_FCM_LSB = 8;
    localparam int EMM_AT_BLK_LSB = 12;
    localparam int EMM_AT_VALID = 15;

    typedef enum logic [2:0] {
        EMM_EMU_RAM = 3'h0,
        EMM_EMU_ROM = 3'h1,
        EMM_TGT_RAM = 3'h2,
        EMM_TGT_ROM = 3'h3,
        EMM_GUARDED = 3'h4
    } emm_type_e;

    typedef struct packed {
        logic valid;
        logic [EMM_BLK_W-1:0] block;
        logic [2:0] fc_mask;
        logic [2:0] fc_value;
        logic fc_en;
        emm_type_e mem_type;
        logic [EMM_PAGE_W-1:0] end_page;
        logic [EMM_PAGE_W-1:0] start_page;
    } emm_entry_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic dma;
        logic [2:0] fc;
        logic [EMM_ADDR_W-1:0] addr;
    } emm_acc_s;

    typedef struct packed {
        logic emu_sel;
        logic emu_we;
        logic tgt_sel;
        logic tgt_we;
        logic brk;
        logic [EMM_BLK_W-1:0] block;
        emm_type_e mem_type;
    } emm_route_s;
endpackage : emm_pkg

// File: rtl/emm_match.sv
// Single range comparator for one mapper entry.
// Assumes entry fields are stable, written by the register file.
`timescale 1ns/1ns
module emm_match (
    input wire emm_pkg::emm_entry_s entry,
    input wire logic [emm_pkg::EMM_ADDR_W-1:0] addr,
    input wire logic [2:0] fc,
    output logic hit
);
    import emm_pkg::*;
    wire logic [EMM_PAGE_W-1:0] page = addr[EMM_ADDR_W-1:EMM_PAGE_LSB];
    wire logic in_range = (page >= entry.start_page) && (page <= entry.end_page);
    wire logic fc_ok = !entry.fc_en ||
        ((fc & entry.fc_mask) == (entry.fc_value & entry.fc_mask));
    assign hit = entry.valid && in_range && fc_ok;
endmodule : emm_match

// File: rtl/emm_mapper.sv
// Emulator memory mapper: range classifier, router, break logic, APB registers.
// Assumes processor access inputs come from logic on ref_clk; no pins sampled.
`timescale 1ns/1ns
module emm_mapper (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire emm_pkg::emm_acc_s cpu_acc,
    output emm_pkg::emm_route_s route,
    output logic [emm_pkg::EMM_ADDR_W-1:0] route_addr,
    input wire logic user_running,
    input wire logic host_brk_req,
    input wire logic host_cmd_exempt,
    output logic host_brk_grant,
    input wire logic host_mem_en,
    input wire logic host_mem_we,
    input wire logic [emm_pkg::EMM_ADDR_W-1:0] host_mem_addr,
    input wire logic [7:0] host_mem_wdata,
    output logic [7:0] host_mem_rdata,
    output logic [7:0] cpu_emu_rdata,
    output logic irq
);
    import emm_pkg::*;

    emm_entry_s ent_reg [EMM_ENTRIES];
    logic [31:0] ctrl_reg;
    logic [EMM_ST_W-1:0] stat_reg, stat_next, mask_reg;
    logic [EMM_ADDR_W-1:0] brk_addr_reg;
    logic [7:0] emu_mem [EMM_NUM_BLOCKS*EMM_BLKWORDS*256];

    function automatic logic is_rom(input emm_type_e t);
        return (t == EMM_EMU_ROM) || (t == EMM_TGT_ROM);
    endfunction : is_rom

    function automatic logic is_emu(input emm_type_e t);
        return (t == EMM_EMU_RAM) || (t == EMM_EMU_ROM);
    endfunction : is_emu

    // APB decode; zero-wait slave
    wire logic apb_acc = psel && penable;
    wire logic apb_wr = apb_acc && pwrite;
    wire logic apb_rd = apb_acc && !pwrite;
    wire logic ent_area = (paddr >= EMM_ENT_BASE_OFS) &&
        (paddr < EMM_ENT_BASE_OFS + 12'(EMM_ENTRIES) * EMM_ENT_STRIDE);
    wire logic [11:0] ent_rel = paddr - EMM_ENT_BASE_OFS;
    wire logic [2:0] ent_idx = ent_rel[6:4];
    wire logic [3:0] ent_word = ent_rel[3:0];
    wire logic ent_ok = ent_area && (ent_word != 4'hC);
    wire logic reg_ok = (paddr == EMM_CTRL_OFS) || (paddr == EMM_STAT_OFS) ||
        (paddr == EMM_MASK_OFS) || (paddr == EMM_BRKA_OFS) || ent_ok;
    wire logic bad = !reg_ok || (paddr[1:0] != 2'b00);

    // Block exclusivity: a write claiming a block already owned elsewhere is refused
    logic blk_clash;
    always_comb begin
        blk_clash = 1'b0;
        for (int i = 0; i < EMM_ENTRIES; i++) begin
            if (3'(i) != ent_idx && ent_reg[i].valid && is_emu(ent_reg[i].mem_type) &&
                ent_reg[i].block == pwdata[EMM_AT_BLK_LSB +: EMM_BLK_W]) begin
                blk_clash = 1'b1;
            end
        end
    end
    wire emm_type_e wr_type = emm_type_e'(pwdata[EMM_AT_TYPE_LSB +: 3]);
    wire logic wr_type_bad = pwdata[EMM_AT_TYPE_LSB +: 3] > 3'h4;
    wire logic attr_bad = ent_ok && ent_word == EMM_EW_ATTR && pwdata[EMM_AT_VALID] &&
        (wr_type_bad || (is_emu(wr_type) && blk_clash));
    wire logic wr_err = bad || (pwrite && attr_bad);

    // Two live emulation ranges on one block would alias each other's memory
    logic blk_dup;
    always_comb begin
        blk_dup = 1'b0;
        for (int i = 0; i < EMM_ENTRIES; i++) begin
            for (int j = i + 1; j < EMM_ENTRIES; j++) begin
                if (ent_reg[i].valid && ent_reg[j].valid && is_emu(ent_reg[i].mem_type) &&
                    is_emu(ent_reg[j].mem_type) &&
                    ent_reg[i].block == ent_reg[j].block) begin
                    blk_dup = 1'b1;
                end
            end
        end
    end

    // Page number of a start or end write; software keeps emulation ranges in one block
    wire logic [EMM_PAGE_W-1:0] wr_page = pwdata[EMM_PAGE_W-1:0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= EMM_CTRL_RST;
            mask_reg <= '0;
            for (int i = 0; i < EMM_ENTRIES; i++) begin
                ent_reg[i] <= '0;
            end
        end else if (apb_wr && !wr_err) begin
            if (paddr == EMM_CTRL_OFS) begin
                ctrl_reg <= pwdata;
            end
            if (paddr == EMM_MASK_OFS) begin
                mask_reg <= pwdata[EMM_ST_W-1:0];
            end
            if (ent_ok) begin
                case (ent_word)
                    EMM_EW_START: ent_reg[ent_idx].start_page <= wr_page;
                    EMM_EW_END: ent_reg[ent_idx].end_page <= wr_page;
                    EMM_EW_ATTR: begin
                        ent_reg[ent_idx].mem_type <= wr_type;
                        ent_reg[ent_idx].fc_en <= pwdata[EMM_AT_FCEN];
                        ent_reg[ent_idx].fc_value <= pwdata[EMM_AT_FC_LSB +: 3];
                        ent_reg[ent_idx].fc_mask <= pwdata[EMM_AT_FCM_LSB +: 3];
                        ent_reg[ent_idx].block <= pwdata[EMM_AT_BLK_LSB +: EMM_BLK_W];
                        ent_reg[ent_idx].valid <= pwdata[EMM_AT_VALID];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Classifier; lowest-numbered hit wins
    logic [EMM_ENTRIES-1:0] hits;
    genvar g;
    generate
        for (g = 0; g < EMM_ENTRIES; g++) begin : g_match
            emm_match u_match (
                .entry(ent_reg[g]),
                .addr(cpu_acc.addr),
                .fc(cpu_acc.fc),
                .hit(hits[g])
            );
        end
    endgenerate

    emm_type_e hit_type;
    logic [EMM_BLK_W-1:0] hit_blk;
    logic any_hit;
    always_comb begin
        hit_type = emm_type_e'(ctrl_reg[EMM_DEF_TYPE_LSB +: 3]);
        hit_blk = '0;
        any_hit = 1'b0;
        for (int i = EMM_ENTRIES - 1; i >= 0; i--) begin
            if (hits[i]) begin
                hit_type = ent_reg[i].mem_type;
                hit_blk = ent_reg[i].block;
                any_hit = 1'b1;
            end
        end
        // Default type may be target or guarded, never emulation
        if (!any_hit && (is_emu(hit_type) || hit_type > EMM_GUARDED)) begin
            hit_type = EMM_TGT_RAM;
        end
    end

    wire logic acc_v = cpu_acc.valid && ctrl_reg[EMM_CTRL_ENA];
    wire logic emu_hit = acc_v && is_emu(hit_type) && !cpu_acc.dma;
    wire logic tgt_hit = acc_v && (!is_emu(hit_type) || cpu_acc.dma);
    wire logic emu_we = emu_hit && cpu_acc.write && hit_type == EMM_EMU_RAM;
    wire logic guard_ev = acc_v && !cpu_acc.dma && hit_type == EMM_GUARDED;
    wire logic romwr_ev = acc_v && !cpu_acc.dma && cpu_acc.write && is_rom(hit_type) &&
        ctrl_reg[EMM_CTRL_ROMBRK];
    wire logic dma_ev = acc_v && cpu_acc.dma && is_emu(hit_type);
    wire logic brk_ev = guard_ev || romwr_ev;
    wire logic rt_block = ctrl_reg[EMM_CTRL_RT] && user_running && !host_cmd_exempt;
    wire logic host_ref = host_brk_req && rt_block;
    wire logic [EMM_BLK_W+EMM_BLOCK_LSB-1:0] cpu_idx =
        {hit_blk, cpu_acc.addr[EMM_BLOCK_LSB-1:0]};
    wire logic [EMM_BLK_W+EMM_BLOCK_LSB-1:0] host_idx =
        host_mem_addr[EMM_BLK_W+EMM_BLOCK_LSB-1:0];
    wire logic rd_clr = apb_rd && paddr == EMM_STAT_OFS;
    wire logic [EMM_ST_W-1:0] stat_set = {host_ref, dma_ev, romwr_ev, guard_ev};

    // Set wins over read-clear
    assign stat_next = (rd_clr ? '0 : stat_reg) | stat_set;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            route <= '0;
            route_addr <= '0;
            stat_reg <= '0;
            brk_addr_reg <= '0;
            irq <= 1'b0;
            host_brk_grant <= 1'b0;
        end else begin
            route.emu_sel <= emu_hit;
            route.emu_we <= emu_we;
            route.tgt_sel <= tgt_hit;
            route.tgt_we <= tgt_hit && cpu_acc.write;
            route.brk <= brk_ev;
            route.block <= hit_blk;
            route.mem_type <= hit_type;
            route_addr <= cpu_acc.addr;
            stat_reg <= stat_next;
            if (brk_ev) begin
                brk_addr_reg <= cpu_acc.addr;
            end
            irq <= |(stat_next & mask_reg);
            host_brk_grant <= host_brk_req && !rt_block;
        end
    end

    // Dual-ported emulation memory, host side independent of processor side
    always_ff @(posedge ref_clk) begin
        if (emu_we) begin
            // No processor write-data port: processor writes store zero
            emu_mem[cpu_idx] <= 8'h00;
        end
        if (host_mem_en && host_mem_we) begin
            emu_mem[host_idx] <= host_mem_wdata;
        end
        cpu_emu_rdata <= emu_mem[cpu_idx];
        host_mem_rdata <= emu_mem[host_idx];
    end

    // APB read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == EMM_CTRL_OFS) rd_mux = ctrl_reg;
        if (paddr == EMM_STAT_OFS) rd_mux = {28'h000_0000, stat_reg};
        if (paddr == EMM_MASK_OFS) rd_mux = {28'h000_0000, mask_reg};
        if (paddr == EMM_BRKA_OFS) rd_mux = {8'h00, brk_addr_reg};
        if (ent_ok && ent_word == EMM_EW_START) rd_mux = {16'h0000, ent_reg[ent_idx].start_page};
        if (ent_ok && ent_word == EMM_EW_END) rd_mux = {16'h0000, ent_reg[ent_idx].end_page};
        if (ent_ok && ent_word == EMM_EW_ATTR) begin
            rd_mux = {16'h0000, ent_reg[ent_idx].valid, ent_reg[ent_idx].block,
                1'b0, ent_reg[ent_idx].fc_mask, 1'b0, ent_reg[ent_idx].fc_value,
                ent_reg[ent_idx].fc_en, ent_reg[ent_idx].mem_type};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (pwrite ? wr_err : bad);
            prdata <= (psel && !penable && !pwrite && !bad) ? rd_mux : 32'h0000_0000;
        end
    end

    AST_GUARD_BRK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        guard_ev |=> route.brk) else $error("guarded access without break");
    AST_ROMWR_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (acc_v && cpu_acc.write && is_rom(hit_type) && !hit_type[2] &&
         !ctrl_reg[EMM_CTRL_ROMBRK] && hit_type != EMM_GUARDED) |=> !route.brk)
        else $error("ROM write break while option off");
    AST_ROMWR_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (acc_v && !cpu_acc.dma && cpu_acc.write && is_rom(hit_type) &&
         ctrl_reg[EMM_CTRL_ROMBRK]) |=> route.brk) else $error("ROM write no break");
    AST_EROM_NOWR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (route.mem_type == EMM_EMU_ROM) |-> !route.emu_we)
        else $error("emulation ROM written");
    AST_TGT_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tgt_hit && cpu_acc.write) |=> (route.tgt_we && route.tgt_sel))
        else $error("target write suppressed");
    AST_DMA: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (acc_v && cpu_acc.dma) |=> !route.emu_sel) else $error("DMA hit emulation");
    AST_DEFAULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (acc_v && hits == '0) |=> !route.emu_sel) else $error("unmapped to emulation");
    AST_RT_REFUSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (host_brk_req && rt_block) |=> !host_brk_grant) else $error("rt break granted");
    AST_EXCL_ROUTE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(route.emu_sel && route.tgt_sel)) else $error("both routes selected");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(stat_reg[EMM_ST_GUARD]) && mask_reg[EMM_ST_GUARD] |-> irq)
        else $error("irq missing");
    AST_BLK_EXCL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !blk_dup) else $error("emulation block shared by two ranges");
    AST_HOST_GRANT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (host_brk_req && !rt_block) |=> host_brk_grant) else $error("host break not granted");
    AST_DMA_STAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dma_ev |=> stat_reg[EMM_ST_DMAREJ]) else $error("DMA status not set");

    COV_GUARD: cover property (@(posedge ref_clk) disable iff (!rst_n) guard_ev);
    COV_ROMWR: cover property (@(posedge ref_clk) disable iff (!rst_n) romwr_ev);
    COV_EMUWR: cover property (@(posedge ref_clk) disable iff (!rst_n) emu_we);
    COV_HOSTREF: cover property (@(posedge ref_clk) disable iff (!rst_n) host_ref);
    COV_DEFGUARD: cover property (@(posedge ref_clk) disable iff (!rst_n)
        acc_v && hits == '0 && hit_type == EMM_GUARDED);
endmodule : emm_mapper

// File: test/emm_cpu_bus_model.sv
// Processor bus and monitor-break partner of the memory mapper.
// Assumes the bench calls issue() just after a rising edge of ref_clk.
`timescale 1ns/1ns
module emm_cpu_bus_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire emm_pkg::emm_route_s route,
    output emm_pkg::emm_acc_s cpu_acc,
    output int brk_count
);
    import emm_pkg::*;
    initial begin
        cpu_acc = '0;
        brk_count = 0;
    end
    // Monitor entry side: one count per break request
    always @(posedge ref_clk) begin
        if (rst_n && route.brk === 1'b1) begin
            brk_count <= brk_count + 1;
        end
    end
    // Released lines show inverted values, so a stale address never matches by luck
    task automatic issue(input logic wr, input logic dma, input logic [2:0] fc,
                         input logic [EMM_ADDR_W-1:0] addr);
        cpu_acc <= '{valid: 1'b1, write: wr, dma: dma, fc: fc, addr: addr};
        @(posedge ref_clk);
        cpu_acc <= '{valid: 1'b0, write: ~wr, dma: ~dma, fc: ~fc, addr: ~addr};
    endtask : issue
endmodule : emm_cpu_bus_model

// File: test/test_emm_mapper.sv
// Self-checking bench of the memory mapper: APB setup, routing, breaks, host port.
// Assumes the design package and the processor bus partner are compiled first.
`timescale 1ns/1ns
module test_emm_mapper;
    import emm_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    emm_acc_s cpu_acc;
    emm_route_s route;
    logic [EMM_ADDR_W-1:0] route_addr;
    logic user_running = 1'b0;
    logic host_brk_req = 1'b0;
    logic host_cmd_exempt = 1'b0;
    logic host_brk_grant;
    logic host_mem_en = 1'b0;
    logic host_mem_we = 1'b0;
    logic [EMM_ADDR_W-1:0] host_mem_addr = 24'h00_0000;
    logic [7:0] host_mem_wdata = 8'h00;
    logic [7:0] host_mem_rdata;
    logic [7:0] cpu_emu_rdata;
    logic irq;
    int brk_count;
    int fail_count = 0;
    int checked = 0;
    logic [31:0] rd;
    logic err;

    always #5 ref_clk = ~ref_clk;

    emm_mapper i_emm_mapper (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_acc(cpu_acc), .route(route), .route_addr(route_addr),
        .user_running(user_running), .host_brk_req(host_brk_req),
        .host_cmd_exempt(host_cmd_exempt), .host_brk_grant(host_brk_grant),
        .host_mem_en(host_mem_en), .host_mem_we(host_mem_we), .host_mem_addr(host_mem_addr),
        .host_mem_wdata(host_mem_wdata), .host_mem_rdata(host_mem_rdata),
        .cpu_emu_rdata(cpu_emu_rdata), .irq(irq));

    emm_cpu_bus_model i_emm_cpu_bus_model (.ref_clk(ref_clk), .rst_n(rst_n), .route(route),
        .cpu_acc(cpu_acc), .brk_count(brk_count));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk({31'h0, err}, {31'h0, e});
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdc

    task automatic ent(input logic [11:0] n, input logic [15:0] sp, input logic [15:0] ep,
                       input logic [2:0] ty, input logic [2:0] fc, input logic fcen,
                       input logic [2:0] blk, input logic e);
        logic [11:0] b;
        b = EMM_ENT_BASE_OFS + n * EMM_ENT_STRIDE;
        wr(b, {16'h0, sp}, 1'b0);
        wr(b + 12'h004, {16'h0, ep}, 1'b0);
        wr(b + 12'h008, {16'h0, 1'b1, blk, 1'b0, {3{fcen}}, 1'b0, fc, fcen, ty}, e);
    endtask : ent

    // Select bits in order emu_sel, emu_we, tgt_sel, tgt_we, brk; type 7 means not checked
    task automatic acc(input logic w, input logic dma, input logic [2:0] fc,
                       input logic [23:0] a, input logic [4:0] m, input logic [4:0] s,
                       input logic [2:0] ty, input logic [2:0] blk);
        @(posedge ref_clk);
        i_emm_cpu_bus_model.issue(w, dma, fc, a);
        @(negedge ref_clk);
        chk({27'h0, m & {route.emu_sel, route.emu_we, route.tgt_sel, route.tgt_we, route.brk}},
            {27'h0, s});
        if (ty !== 3'h7) chk({29'h0, route.mem_type}, {29'h0, ty});
        if (s[4]) chk({29'h0, route.block}, {29'h0, blk});
        chk({8'h0, route_addr}, {8'h0, a});
    endtask : acc

    task automatic host(input logic w, input logic [23:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        host_mem_en <= 1'b1;
        host_mem_we <= w;
        host_mem_addr <= a;
        host_mem_wdata <= d;
        @(posedge ref_clk);
        host_mem_en <= 1'b0;
        @(negedge ref_clk);
    endtask : host

    task automatic hbrk(input logic ex, input logic g);
        @(posedge ref_clk);
        host_brk_req <= 1'b1;
        host_cmd_exempt <= ex;
        @(posedge ref_clk);
        host_brk_req <= 1'b0;
        @(negedge ref_clk);
        chk({31'h0, host_brk_grant}, {31'h0, g});
    endtask : hbrk

    task automatic results();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // Whole run is under two hundred cycles; this leaves wide margin
    initial begin
        #100000;
        fail_count++;
        results();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdc(EMM_CTRL_OFS, EMM_CTRL_RST);
        wr(12'h010, 32'h0000_0001, 1'b1);
        wr(EMM_CTRL_OFS, 32'h0000_0004, 1'b0);
        ent(12'h000, 16'h0000, 16'h004f, EMM_EMU_ROM, 3'h0, 1'b0, 3'h0, 1'b0);
        ent(12'h001, 16'h0070, 16'h008f, EMM_EMU_RAM, 3'h0, 1'b0, 3'h1, 1'b0);
        ent(12'h002, 16'h0200, 16'h02ff, EMM_GUARDED, 3'h0, 1'b0, 3'h0, 1'b0);
        ent(12'h003, 16'h0300, 16'h03ff, EMM_TGT_ROM, 3'h0, 1'b0, 3'h0, 1'b0);
        ent(12'h004, 16'h0600, 16'h060f, EMM_EMU_RAM, 3'h5, 1'b1, 3'h2, 1'b0);
        ent(12'h005, 16'h0600, 16'h060f, EMM_EMU_RAM, 3'h1, 1'b1, 3'h3, 1'b0);
        ent(12'h006, 16'h0700, 16'h070f, EMM_EMU_RAM, 3'h0, 1'b0, 3'h0, 1'b1);
        ent(12'h007, 16'h0800, 16'h080f, 3'h5, 3'h0, 1'b0, 3'h4, 1'b1);
        wr(EMM_ENT_BASE_OFS + 12'h080, 32'h0000_0001, 1'b1);
        apb(1'b0, EMM_STAT_OFS, 32'h0000_0000);
        wr(EMM_MASK_OFS, 32'h0000_0001, 1'b0);
        acc(1'b0, 1'b0, 3'h0, 24'h00_1234, 5'h1f, 5'h10, EMM_EMU_ROM, 3'h0);
        acc(1'b1, 1'b0, 3'h0, 24'h00_1234, 5'h0f, 5'h00, EMM_EMU_ROM, 3'h0);
        acc(1'b1, 1'b0, 3'h0, 24'h00_7000, 5'h1f, 5'h18, EMM_EMU_RAM, 3'h1);
        acc(1'b0, 1'b0, 3'h0, 24'h00_8fff, 5'h1f, 5'h10, EMM_EMU_RAM, 3'h1);
        acc(1'b0, 1'b0, 3'h0, 24'h00_6fff, 5'h1f, 5'h04, EMM_TGT_RAM, 3'h0);
        acc(1'b0, 1'b0, 3'h0, 24'h00_9000, 5'h1f, 5'h04, EMM_TGT_RAM, 3'h0);
        acc(1'b0, 1'b1, 3'h0, 24'h00_7100, 5'h1c, 5'h04, 3'h7, 3'h0);
        acc(1'b0, 1'b0, 3'h0, 24'h02_0010, 5'h19, 5'h01, EMM_GUARDED, 3'h0);
        acc(1'b1, 1'b0, 3'h0, 24'h02_0020, 5'h1b, 5'h03, EMM_GUARDED, 3'h0);
        acc(1'b1, 1'b0, 3'h0, 24'h03_0000, 5'h1f, 5'h06, EMM_TGT_ROM, 3'h0);
        acc(1'b0, 1'b0, 3'h5, 24'h06_0080, 5'h1f, 5'h10, EMM_EMU_RAM, 3'h2);
        acc(1'b0, 1'b0, 3'h1, 24'h06_0080, 5'h1f, 5'h10, EMM_EMU_RAM, 3'h3);
        acc(1'b0, 1'b0, 3'h3, 24'h06_0080, 5'h1f, 5'h04, EMM_TGT_RAM, 3'h0);
        repeat (2) @(negedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0001);
        rdc(EMM_STAT_OFS, 32'h0000_0005);
        rdc(EMM_BRKA_OFS, 32'h0002_0020);
        repeat (3) @(negedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(EMM_CTRL_OFS, 32'h0000_0005, 1'b0);
        acc(1'b1, 1'b0, 3'h0, 24'h03_0000, 5'h1f, 5'h07, EMM_TGT_ROM, 3'h0);
        acc(1'b1, 1'b0, 3'h0, 24'h00_0100, 5'h0f, 5'h01, EMM_EMU_ROM, 3'h0);
        repeat (2) @(negedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        rdc(EMM_STAT_OFS, 32'h0000_0002);
        user_running <= 1'b1;
        host(1'b1, 24'h00_1020, 8'h5a);
        host(1'b1, 24'h00_7200, 8'hc3);
        acc(1'b1, 1'b0, 3'h0, 24'h00_1020, 5'h0f, 5'h01, EMM_EMU_ROM, 3'h0);
        acc(1'b0, 1'b0, 3'h0, 24'h00_1020, 5'h1f, 5'h10, EMM_EMU_ROM, 3'h0);
        chk({24'h0, cpu_emu_rdata}, 32'h0000_005a);
        host(1'b0, 24'h00_7200, 8'h00);
        chk({24'h0, host_mem_rdata}, 32'h0000_00c3);
        apb(1'b0, EMM_STAT_OFS, 32'h0000_0000);
        wr(EMM_CTRL_OFS, 32'h0000_0006, 1'b0);
        hbrk(1'b0, 1'b0);
        hbrk(1'b1, 1'b1);
        rdc(EMM_STAT_OFS, 32'h0000_0008);
        wr(EMM_CTRL_OFS, 32'h0000_0004, 1'b0);
        hbrk(1'b0, 1'b1);
        wr(EMM_CTRL_OFS, 32'h0000_0014, 1'b0);
        acc(1'b0, 1'b0, 3'h0, 24'h09_0000, 5'h1f, 5'h04, EMM_TGT_RAM, 3'h0);
        wr(EMM_CTRL_OFS, 32'h0000_0044, 1'b0);
        acc(1'b0, 1'b0, 3'h0, 24'h09_0000, 5'h1f, 5'h05, EMM_GUARDED, 3'h0);
        chk({31'h0, irq}, 32'h0000_0001);
        // Partner counts the break one edge after route shows it
        @(negedge ref_clk);
        chk(brk_count, 32'h0000_0006);
        results();
    end
endmodule : test_emm_mapper
